/* hdl/csc_pkg.sv */
// Constants, field layouts and carrier types for the sense amplifier control
package csc_pkg;

  // Register addresses carried in the serial frame
  localparam logic [3:0] ADDR_DRIVE_HS = 4'h3;
  localparam logic [3:0] ADDR_DRIVE_LS = 4'h4;
  localparam logic [3:0] ADDR_SENSE_CTRL = 4'h6;

  // Register width and reset values
  localparam int unsigned REG_W = 11;
  localparam logic [10:0] RST_SENSE_CTRL = 11'h283;
  localparam logic [10:0] RST_DRIVE_HS = 11'h0ff;
  localparam logic [10:0] RST_DRIVE_LS = 11'h3ff;

  // Field positions in the sense control register
  localparam int unsigned POS_INPUT_SEL = 10;
  localparam int unsigned POS_LOWSIDE_REF = 8;

  // Field positions in the drive registers
  localparam int unsigned POS_PEAK_HI = 9;
  localparam int unsigned POS_PEAK_LO = 8;
  localparam int unsigned POS_SRC_HI = 7;
  localparam int unsigned POS_SRC_LO = 4;
  localparam int unsigned POS_SINK_HI = 3;
  localparam int unsigned POS_SINK_LO = 0;

  // Serial frame layout: read flag, 4 address bits, 11 data bits
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HDR_BITS = 5'h05;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h04;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam int unsigned POS_READ_FLAG = 15;

  // Peak drive time settings and their length in clock cycles
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned PEAK_NS_0 = 500;
  localparam int unsigned PEAK_NS_1 = 1000;
  localparam int unsigned PEAK_NS_2 = 2000;
  localparam int unsigned PEAK_NS_3 = 4000;
  localparam logic [6:0] PEAK_CYC_0 = 7'(PEAK_NS_0 * CLK_MHZ / 1000);
  localparam logic [6:0] PEAK_CYC_1 = 7'(PEAK_NS_1 * CLK_MHZ / 1000);
  localparam logic [6:0] PEAK_CYC_2 = 7'(PEAK_NS_2 * CLK_MHZ / 1000);
  localparam logic [6:0] PEAK_CYC_3 = 7'(PEAK_NS_3 * CLK_MHZ / 1000);

  // Sense amplifier control fields, laid out as the register bits
  typedef struct packed {
    logic amp_input_select;
    logic ref_div_half;
    logic lowside_meas_ref;
    logic [1:0] amp_gain_select;
    logic sense_fault_disable;
    logic offset_cal_chan_a;
    logic offset_cal_chan_b;
    logic offset_cal_chan_c;
    logic [1:0] sense_trip_level;
  } csc_ctrl_t;

  // Gate drive settings in effect
  typedef struct packed {
    logic [1:0] peak_drive_time;
    logic [3:0] src_hs;
    logic [3:0] sink_hs;
    logic [3:0] src_ls;
    logic [3:0] sink_ls;
  } csc_drive_t;

  // Gate monitor states
  typedef enum logic [1:0] {
    GM_IDLE = 2'b01,
    GM_WAIT = 2'b10
  } csc_gm_state_t;

  // Peak drive time code to cycle count
  function automatic logic [6:0] peak_cycles(input logic [1:0] code);
    case (code)
      2'h0: peak_cycles = PEAK_CYC_0;
      2'h1: peak_cycles = PEAK_CYC_1;
      2'h2: peak_cycles = PEAK_CYC_2;
      default: peak_cycles = PEAK_CYC_3;
    endcase
  endfunction

endpackage

/* hdl/csc_gate_mon.sv */
// Gate turn-on monitor raising a drive fault when peak time runs out
`timescale 1ns/1ps
`default_nettype none
module csc_gate_mon
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] peak_code,
  input wire logic gate_on_req,
  input wire logic gate_on_done,
  output logic gate_drive_fault
);

  csc_gm_state_t state_r;
  logic [6:0] left_r;

  // Peak time window per turn-on
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= GM_IDLE;
      left_r <= 7'h00;
    end else begin
      case (state_r)
        GM_IDLE: begin
          if (gate_on_req) begin
            state_r <= GM_WAIT;
            left_r <= peak_cycles(peak_code);
          end
        end
        GM_WAIT: begin
          if (gate_on_done || left_r == 7'h01) begin
            state_r <= GM_IDLE;
          end
          left_r <= left_r - 7'h01;
        end
        default: begin
          state_r <= GM_IDLE;
        end
      endcase
    end
  end

  // Fault when the gate is not fully on by the end of peak time
  always_ff @(posedge clock) begin
    if (rst) begin
      gate_drive_fault <= 1'b0;
    end else begin
      gate_drive_fault <= state_r == GM_WAIT && !gate_on_done &&
                          left_r == 7'h01;
    end
  end

endmodule
`default_nettype wire

/* hdl/csc_ctrl_top.sv */
// Sense amplifier control register with its serial register port
//
// How it works
// - Input select 1 takes switch node input and forces lowside ref bit.
// - Reference divide bit: 0 full reference, 1 half; resets to 1.
// - Gain field 5/10/20/40 V/V, resets to code 10.
// - Sense fault disable bit, resets to 0, 1 disables the fault.
// - Bits 4..2 short amplifier A, B, C inputs for offset calibration.
// - Trip level field 0.25/0.5/0.75/1 V, resets to code 11.
// - Register at address 6 is read/write, present only with amps.
// - Too little drive current may give a gate drive fault.
// - Serial variant sets drive currents by register, pin variant by pin.
// - Peak drive time codes give 500, 1000, 2000, 4000 ns.
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_top
  import csc_pkg::*;
#(
  parameter bit HAS_AMPS = 1'b1,
  parameter bit SERIAL_IF = 1'b1
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic [3:0] drive_strength_pin,
  input wire logic gate_on_req,
  input wire logic gate_on_done,
  output csc_ctrl_t sense_cfg,
  output csc_drive_t drive_cfg,
  output logic gate_drive_fault
);

  logic sclk_q_r;
  logic cs_n_q_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] rx_r;
  logic [3:0] addr_r;
  logic [10:0] drive_hs_r;
  logic [10:0] drive_ls_r;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_end;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [10:0] wr_data;
  logic [3:0] tx_idx;

  // Read word for an address; unmapped addresses read zero
  function automatic logic [10:0] read_word(input logic [3:0] addr,
                                            input csc_ctrl_t ctrl,
                                            input logic [10:0] hs,
                                            input logic [10:0] ls);
    read_word = 11'h000;
    case (addr)
      ADDR_SENSE_CTRL: read_word = HAS_AMPS ? ctrl : 11'h000;
      ADDR_DRIVE_HS: read_word = hs;
      ADDR_DRIVE_LS: read_word = ls;
      default: read_word = 11'h000;
    endcase
  endfunction

  assign sclk_fall = sclk_q_r && !spi_sclk;
  assign sclk_rise = !sclk_q_r && spi_sclk;
  assign frame_end = !cs_n_q_r && spi_cs_n;
  assign wr_en = frame_end && bit_cnt_r == FRAME_BITS &&
                 !rx_r[POS_READ_FLAG];
  assign wr_addr = rx_r[14:11];
  assign wr_data = rx_r[10:0];
  assign tx_idx = 4'(5'h0f - bit_cnt_r);

  // Edge detect on the serial pins
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_q_r <= 1'b0;
      cs_n_q_r <= 1'b1;
    end else begin
      sclk_q_r <= spi_sclk;
      cs_n_q_r <= spi_cs_n;
    end
  end

  // Receive shifter, data taken on falling serial clock
  always_ff @(posedge clock) begin
    if (rst) begin
      bit_cnt_r <= 5'h00;
      rx_r <= 16'h0000;
    end else if (spi_cs_n) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_fall) begin
      rx_r <= {rx_r[14:0], spi_sdi};
      if (bit_cnt_r != CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // Address caught once the header is in
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_r <= 4'h0;
    end else if (!spi_cs_n && sclk_fall && bit_cnt_r == ADDR_LAST_BIT) begin
      addr_r <= {rx_r[2:0], spi_sdi};
    end
  end

  // Reply: five zero header bits, then the register word
  always_ff @(posedge clock) begin
    if (rst) begin
      spi_sdo <= 1'b0;
    end else if (spi_cs_n) begin
      spi_sdo <= 1'b0;
    end else if (sclk_rise) begin
      if (bit_cnt_r >= HDR_BITS && bit_cnt_r < FRAME_BITS) begin
        spi_sdo <= read_word(addr_r, sense_cfg, drive_hs_r,
                             drive_ls_r)[tx_idx];
      end else begin
        spi_sdo <= 1'b0;
      end
    end
  end

  // Data out driven while selected
  always_ff @(posedge clock) begin
    if (rst) begin
      spi_sdo_oe <= 1'b0;
    end else begin
      spi_sdo_oe <= !spi_cs_n;
    end
  end

  // Sense amplifier control register
  always_ff @(posedge clock) begin
    if (rst) begin
      sense_cfg <= csc_ctrl_t'(RST_SENSE_CTRL);
    end else if (HAS_AMPS && wr_en && wr_addr == ADDR_SENSE_CTRL) begin
      sense_cfg <= csc_ctrl_t'(wr_data);
      sense_cfg.lowside_meas_ref <= wr_data[POS_LOWSIDE_REF] |
                                    wr_data[POS_INPUT_SEL];
    end
  end

  // Drive current registers, serial variant only
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_hs_r <= RST_DRIVE_HS;
      drive_ls_r <= RST_DRIVE_LS;
    end else if (SERIAL_IF && wr_en) begin
      if (wr_addr == ADDR_DRIVE_HS) begin
        drive_hs_r <= {3'h0, wr_data[7:0]};
      end
      if (wr_addr == ADDR_DRIVE_LS) begin
        drive_ls_r <= {1'b0, wr_data[9:0]};
      end
    end
  end

  // Drive settings in effect
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_cfg <= '{RST_DRIVE_LS[POS_PEAK_HI:POS_PEAK_LO],
                     RST_DRIVE_HS[POS_SRC_HI:POS_SRC_LO],
                     RST_DRIVE_HS[POS_SINK_HI:POS_SINK_LO],
                     RST_DRIVE_LS[POS_SRC_HI:POS_SRC_LO],
                     RST_DRIVE_LS[POS_SINK_HI:POS_SINK_LO]};
    end else if (SERIAL_IF) begin
      drive_cfg.peak_drive_time <= drive_ls_r[POS_PEAK_HI:POS_PEAK_LO];
      drive_cfg.src_hs <= drive_hs_r[POS_SRC_HI:POS_SRC_LO];
      drive_cfg.sink_hs <= drive_hs_r[POS_SINK_HI:POS_SINK_LO];
      drive_cfg.src_ls <= drive_ls_r[POS_SRC_HI:POS_SRC_LO];
      drive_cfg.sink_ls <= drive_ls_r[POS_SINK_HI:POS_SINK_LO];
    end else begin
      drive_cfg.peak_drive_time <= RST_DRIVE_LS[POS_PEAK_HI:POS_PEAK_LO];
      drive_cfg.src_hs <= drive_strength_pin;
      drive_cfg.sink_hs <= drive_strength_pin;
      drive_cfg.src_ls <= drive_strength_pin;
      drive_cfg.sink_ls <= drive_strength_pin;
    end
  end

  // Gate turn-on supervision against the peak drive time
  csc_gate_mon u_gate_mon (
    .clock(clock),
    .rst(rst),
    .peak_code(drive_cfg.peak_drive_time),
    .gate_on_req(gate_on_req),
    .gate_on_done(gate_on_done),
    .gate_drive_fault(gate_drive_fault)
  );

endmodule
`default_nettype wire

/* tb/csc_ctrl_top_props.sv */
// Port checker for the sense amplifier control block
`timescale 1ns/1ps
`default_nettype none
module csc_ctrl_props
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic gate_on_done,
  input wire csc_ctrl_t sense_cfg,
  input wire csc_drive_t drive_cfg,
  input wire logic gate_drive_fault
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_force_ref;
    sense_cfg.amp_input_select |-> sense_cfg.lowside_meas_ref;
  endproperty
  a_force_ref: assert property (p_force_ref)
    else $error("lowside ref not forced");
  property p_rst_val;
    $fell(rst) |-> sense_cfg == 11'h283;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("sense reset value wrong");
  property p_drv_rst;
    $fell(rst) |-> drive_cfg == {2'h3, 16'hffff};
  endproperty
  a_drv_rst: assert property (p_drv_rst)
    else $error("drive reset value wrong");
  property p_cfg_hold;
    !spi_cs_n ##1 !spi_cs_n |-> $stable(sense_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("sense fields moved inside a frame");
  property p_drv_hold;
    !spi_cs_n [*3] |-> $stable(drive_cfg);
  endproperty
  a_drv_hold: assert property (p_drv_hold)
    else $error("drive fields moved inside a frame");
  property p_oe;
    spi_sdo_oe == !$past(spi_cs_n);
  endproperty
  a_oe: assert property (p_oe)
    else $error("output enable not following select");
  property p_fault_gap;
    gate_drive_fault |=> !gate_drive_fault [*8];
  endproperty
  a_fault_gap: assert property (p_fault_gap)
    else $error("gate fault repeated too soon");
  property p_fault_done;
    gate_on_done [*2] |=> !gate_drive_fault;
  endproperty
  a_fault_done: assert property (p_fault_done)
    else $error("gate fault despite full turn-on");
  c_fault: cover property (gate_drive_fault);
  c_forced: cover property (sense_cfg.amp_input_select);
  c_frame: cover property ($rose(spi_cs_n));
endmodule
bind csc_ctrl_top csc_ctrl_props u_props (.clock, .rst, .spi_cs_n,
  .spi_sdo_oe, .gate_on_done, .sense_cfg, .drive_cfg, .gate_drive_fault);
`default_nettype wire

/* tb/csc_host_model.sv */
// Host serial master sending register frames to the block
`timescale 1ns/1ps
`default_nettype none
module csc_host_model (
  input wire logic clock,
  input wire logic spi_sdo,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // Sends the top n bits of a frame, gathers the reply bits
  task automatic xfer(input logic [15:0] f, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    spi_cs_n <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 15; i > 15 - n; i--) begin
      spi_sclk <= 1'b1;
      spi_sdi <= f[i];
      repeat (4) @(posedge clock);
      r[i] = spi_sdo;
      spi_sclk <= 1'b0;
      repeat (3) @(posedge clock);
    end
    spi_cs_n <= 1'b1;
    spi_sdi <= ~f[16 - n];
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* tb/tb_current_sense_amp_control.sv */
// Self-checking bench for the sense amplifier control block
`timescale 1ns/1ps
`default_nettype none
module tb_current_sense_amp_control
  import csc_pkg::*;
  ;
  logic clock, rst, gate_on_req, gate_on_done, gate_drive_fault;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  csc_ctrl_t sense_cfg;
  csc_drive_t drive_cfg;
  logic [15:0] rd;
  int miscompares, comparisons;
  csc_ctrl_top DUT (.clock, .rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
    .spi_sdo_oe, .drive_strength_pin(4'h0), .gate_on_req, .gate_on_done,
    .sense_cfg, .drive_cfg, .gate_drive_fault);
  csc_host_model u_host (.clock, .spi_sdo, .spi_sclk, .spi_cs_n, .spi_sdi);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input string what, input logic [17:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    u_host.xfer({1'b0, a, d}, 16, rd);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [10:0] e);
    u_host.xfer({1'b1, a, 11'h000}, 16, rd);
    check("readback", {2'b00, rd}, {7'h00, e});
  endtask
  task automatic test_reset();
    check("sense_rst", {7'h00, sense_cfg}, 18'h00283);
    check("drive_rst", drive_cfg, 18'h3ffff);
    rd_chk(4'h6, 11'h283);
  endtask
  task automatic test_fields();
    logic [10:0] v[6] = '{11'h100, 11'h045, 11'h28a, 11'h2ff, 11'h000,
                          11'h400};
    logic [10:0] e;
    foreach (v[i]) begin
      e = v[i] | {2'b00, v[i][10], 8'h00};
      wr(4'h6, v[i]);
      check("sense_cfg", {7'h00, sense_cfg}, {7'h00, e});
      rd_chk(4'h6, e);
    end
  endtask
  task automatic test_refused();
    u_host.xfer({1'b0, 4'h6, 11'h000}, 15, rd);
    check("short_frame", {7'h00, sense_cfg}, 18'h00500);
    u_host.xfer({1'b1, 4'h6, 11'h0ff}, 16, rd);
    check("read_frame", {7'h00, sense_cfg}, 18'h00500);
    wr(4'h7, 11'h7ff);
    rd_chk(4'h7, 11'h000);
  endtask
  task automatic test_drive();
    wr(4'h3, 11'h0a5);
    wr(4'h4, 11'h13c);
    check("drive_cfg", drive_cfg, {2'h1, 16'ha53c});
    rd_chk(4'h4, 11'h13c);
  endtask
  task automatic test_gate(input logic [1:0] code, input int win);
    int n;
    wr(4'h4, {1'b0, code, 8'h3c});
    gate_on_req <= 1'b1;
    @(posedge clock);
    gate_on_req <= 1'b0;
    n = 0;
    while (gate_drive_fault !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 200) begin
        miscompares++;
        complete_run();
      end
    end
    check("fault_time", {17'h0, n >= win - 1 && n <= win + 3}, 18'h1);
    @(negedge clock);
    check("fault_pulse", {17'h0, gate_drive_fault}, 18'h0);
    @(posedge clock);
  endtask
  task automatic test_done();
    logic seen;
    seen = 1'b0;
    gate_on_req <= 1'b1;
    @(posedge clock);
    gate_on_req <= 1'b0;
    repeat (40) @(posedge clock);
    gate_on_done <= 1'b1;
    repeat (120) begin
      @(negedge clock);
      seen = seen | gate_drive_fault;
    end
    check("fault_quiet", {17'h0, seen}, 18'h0);
    @(posedge clock);
    gate_on_done <= 1'b0;
  endtask
  task automatic test_rereset();
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("sense_rerst", {7'h00, sense_cfg}, 18'h00283);
  endtask
  initial begin
    rst = 1'b1;
    gate_on_req = 1'b0;
    gate_on_done = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_fields();
    test_refused();
    test_drive();
    for (int c = 0; c < 4; c++) begin
      test_gate(2'(c), (500 << c) / 40);
    end
    test_done();
    test_rereset();
    complete_run();
  end
endmodule
`default_nettype wire
